// ==== src/rivm_vector_map.sv ====
// Notes on behaviour
// - Every reset source fetches vector one, at address 0x0000 while the boot fuse is unprogrammed.
// - External request zero dispatches to vector 2 at 0x0002.
// - Pin change groups zero and one go to 0x0004 and 0x0006.
// - Pin change groups two and three go to 0x002E and 0x0030.
// - Timer two events at 0x0008/0x000A, timer zero at 0x0014/0x0016.
// - Timer one capture, compare A, compare B, overflow at 0x000C..0x0012.
// - SPI done at 0x0018; serial unit start and overflow at 0x0020/0x0022.
// - USART receive, data empty, transmit done at 0x001A, 0x001C, 0x001E.
// - Comparator 0x0024, converter 0x0026, EEPROM ready 0x0028.
// - Self program ready at 0x002A; vector 23 at 0x002C is never used.
// - With table select set, interrupt addresses add the boot section start.
// - Programmed boot fuse sends reset to the boot loader entry.
// - Fuse value one is unprogrammed, zero is programmed.
// - Reset target and interrupt base are selected independently.
`timescale 1ns/1ps
`default_nettype none
`include "rivm_defs.svh"

module rivm_vector_map (
  input wire logic CLK,
  input wire logic SRST,
  input wire rivm_pkg::rivm_reset_cause_s RESET_CAUSE,
  input wire logic [`RIVM_IRQ_W-1:0] IRQ_REQ,
  input wire logic BOOT_RESET_SELECT_FUSE,
  input wire logic VECTOR_TABLE_SELECT,
  input wire rivm_pkg::rivm_addr_t BOOT_ENTRY_ADDR,
  input wire logic FETCH_ACK,
  output logic VEC_VALID,
  output rivm_pkg::rivm_addr_t VEC_ADDR,
  output rivm_pkg::rivm_num_t VEC_NUM,
  output logic VEC_IS_RESET
);
  import rivm_pkg::*;

  // ========================================================================
  // Request decode
  // ========================================================================
  // Lowest numbered pending line wins; bit i stands for vector i plus two.
  function automatic rivm_num_t rivm_first_vec(input logic [`RIVM_IRQ_W-1:0] req);
    rivm_num_t v;
    v = `RIVM_VEC_NONE;
    for (int i = `RIVM_IRQ_W - 1; i >= 0; i--) begin
      if (req[i]) begin
        v = rivm_num_t'(i) + `RIVM_VEC_FIRST_IRQ;
      end
    end
    return v;
  endfunction : rivm_first_vec

  rivm_state_e state_ff;
  rivm_state_e nxt_state;
  logic rst_pend_ff;
  logic nxt_rst_pend;
  logic valid_ff;
  logic nxt_valid;
  rivm_num_t num_ff;
  rivm_num_t nxt_num;
  logic is_reset_ff;
  logic nxt_is_reset;
  logic fuse_ff;
  logic sel_ff;
  rivm_addr_t boot_ff;

  // The reserved slot has no source, so its line is dropped here.
  wire logic [`RIVM_IRQ_W-1:0] reserved_mask = ~(`RIVM_IRQ_W'(1) << `RIVM_RESERVED_BIT);
  wire logic [`RIVM_IRQ_W-1:0] req_live = IRQ_REQ & reserved_mask;
  wire logic any_cause = |RESET_CAUSE;
  wire logic take_reset = rst_pend_ff | any_cause;
  wire logic idle = (state_ff == ST_IDLE);
  wire logic capture = idle & (take_reset | (|req_live));
  wire logic capture_reset = idle & take_reset;
  // Fixed slot numbering gives every listed address via the calculator.
  wire rivm_num_t irq_vec = rivm_first_vec(req_live);

  // ========================================================================
  // Next state
  // ========================================================================
  // A reset seen during capture of the previous one stays pending.
  assign nxt_rst_pend = any_cause | (rst_pend_ff & ~capture_reset);
  assign nxt_valid = capture | (valid_ff & ~FETCH_ACK);
  assign nxt_num = capture ? (take_reset ? `RIVM_VEC_RESET : irq_vec) : num_ff;
  assign nxt_is_reset = capture ? take_reset : is_reset_ff;

  // Dispatch sequencing.
  always_comb begin
    case (state_ff)
      ST_IDLE: nxt_state = capture ? ST_HOLD : ST_IDLE;
      ST_HOLD: nxt_state = FETCH_ACK ? ST_IDLE : ST_HOLD;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ========================================================================
  // Registers
  // ========================================================================
  // System reset itself leaves the reset vector pending.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_ff <= ST_IDLE;
      rst_pend_ff <= 1'b1;
      valid_ff <= 1'b0;
      num_ff <= `RIVM_VEC_NONE;
      is_reset_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rst_pend_ff <= nxt_rst_pend;
      valid_ff <= nxt_valid;
      num_ff <= nxt_num;
      is_reset_ff <= nxt_is_reset;
    end
  end

  // Settings in force when a vector is taken, kept for checking.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      fuse_ff <= 1'b1;
      sel_ff <= 1'b0;
      boot_ff <= `RIVM_RESET_ADDR;
    end else if (capture) begin
      fuse_ff <= BOOT_RESET_SELECT_FUSE;
      sel_ff <= VECTOR_TABLE_SELECT;
      boot_ff <= BOOT_ENTRY_ADDR;
    end
  end

  // ========================================================================
  // Address calculation
  // ========================================================================
  // The address is formed from the same inputs that the capture edge samples.
  rivm_addr_calc u_calc (
    .clk(CLK),
    .srst(SRST),
    .load(capture),
    .is_reset(take_reset),
    .vec_num(nxt_num),
    .boot_fuse(BOOT_RESET_SELECT_FUSE),
    .table_sel(VECTOR_TABLE_SELECT),
    .boot_entry(BOOT_ENTRY_ADDR),
    .addr_ff(VEC_ADDR)
  );

  // Outputs come straight from their registers.
  assign VEC_VALID = valid_ff;
  assign VEC_NUM = num_ff;
  assign VEC_IS_RESET = is_reset_ff;

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  reset_addr_a: assert property (
    VEC_VALID && VEC_IS_RESET && fuse_ff |-> VEC_ADDR == `RIVM_RESET_ADDR)
    else $error("reset vector not at zero");
  boot_reset_a: assert property (
    VEC_VALID && VEC_IS_RESET && !fuse_ff |-> VEC_ADDR == boot_ff)
    else $error("boot reset address wrong");
  ext_zero_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_FIRST_IRQ && !sel_ff |-> VEC_ADDR == `RIVM_ADDR_EXT_ZERO)
    else $error("external request zero address wrong");
  pin_zero_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_PIN_ZERO && !sel_ff |-> VEC_ADDR == `RIVM_ADDR_PIN_ZERO)
    else $error("pin change zero address wrong");
  pin_one_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_PIN_ONE && !sel_ff |-> VEC_ADDR == `RIVM_ADDR_PIN_ONE)
    else $error("pin change one address wrong");
  pin_two_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_PIN_TWO && !sel_ff |-> VEC_ADDR == `RIVM_ADDR_PIN_TWO)
    else $error("pin change two address wrong");
  pin_three_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_PIN_THREE && !sel_ff
    |-> VEC_ADDR == `RIVM_ADDR_PIN_THREE)
    else $error("pin change three address wrong");
  tmr_two_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_TMR_TWO_CMP && !sel_ff
    |-> VEC_ADDR == `RIVM_ADDR_TMR_TWO_CMP)
    else $error("timer two compare address wrong");
  tmr_zero_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_TMR_ZERO_OVF && !sel_ff
    |-> VEC_ADDR == `RIVM_ADDR_TMR_ZERO_OVF)
    else $error("timer zero overflow address wrong");
  tmr_one_capt_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_TMR_ONE_CAPT && !sel_ff
    |-> VEC_ADDR == `RIVM_ADDR_TMR_ONE_CAPT)
    else $error("timer one capture address wrong");
  tmr_one_ovf_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_TMR_ONE_OVF && !sel_ff
    |-> VEC_ADDR == `RIVM_ADDR_TMR_ONE_OVF)
    else $error("timer one overflow address wrong");
  spi_done_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_SPI_DONE && !sel_ff |-> VEC_ADDR == `RIVM_ADDR_SPI_DONE)
    else $error("spi vector address wrong");
  serial_start_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_SERIAL_START && !sel_ff
    |-> VEC_ADDR == `RIVM_ADDR_SERIAL_START)
    else $error("serial unit start address wrong");
  usart_rx_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_USART_RX && !sel_ff
    |-> VEC_ADDR == `RIVM_ADDR_USART_RX)
    else $error("usart receive address wrong");
  eeprom_rdy_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_EEPROM && !sel_ff
    |-> VEC_ADDR == `RIVM_ADDR_EEPROM)
    else $error("eeprom ready address wrong");
  self_prog_a: assert property (
    VEC_VALID && VEC_NUM == `RIVM_VEC_SELF_PROG && !sel_ff
    |-> VEC_ADDR == `RIVM_ADDR_SELF_PROG)
    else $error("self program ready address wrong");
  boot_table_a: assert property (
    VEC_VALID && !VEC_IS_RESET && sel_ff
    |-> VEC_ADDR - boot_ff == `RIVM_ADDR_W'({VEC_NUM - `RIVM_VEC_RESET, 1'b0}))
    else $error("boot table offset wrong");
  no_reserved_a: assert property (
    VEC_VALID |-> VEC_NUM != `RIVM_VEC_RESERVED && VEC_NUM != `RIVM_VEC_NONE)
    else $error("reserved vector dispatched");
  reset_first_a: assert property (
    idle && any_cause |=> VEC_VALID && VEC_IS_RESET && VEC_NUM == `RIVM_VEC_RESET)
    else $error("reset did not win dispatch");
  hold_vec_a: assert property (
    VEC_VALID && !FETCH_ACK |=> VEC_VALID && $stable(VEC_ADDR) [*1])
    else $error("vector dropped before fetch");

  reset_cov_c: cover property (VEC_VALID && VEC_IS_RESET && !fuse_ff);
  irq_cov_c: cover property (VEC_VALID && !VEC_IS_RESET ##1 FETCH_ACK);
  boot_tbl_c: cover property (VEC_VALID && sel_ff && !VEC_IS_RESET);
  back_c: cover property (FETCH_ACK ##1 idle ##1 VEC_VALID);
  two_reset_c: cover property (VEC_VALID && VEC_IS_RESET && rst_pend_ff);

endmodule : rivm_vector_map

`default_nettype wire

// ==== src/rivm_defs.svh ====
`ifndef RIVM_DEFS_SVH
`define RIVM_DEFS_SVH

// ==========================================================================
// Widths
// ==========================================================================
`define RIVM_ADDR_W 16
`define RIVM_NUM_W 5
`define RIVM_IRQ_W 24

// ==========================================================================
// Vector numbers and addresses
// ==========================================================================
`define RIVM_VEC_RESET 5'h01
`define RIVM_VEC_FIRST_IRQ 5'h02
`define RIVM_VEC_RESERVED 5'h17
`define RIVM_VEC_NONE 5'h00
`define RIVM_RESERVED_BIT 21
`define RIVM_RESET_ADDR 16'h0000
`define RIVM_APP_BASE 16'h0000
`define RIVM_ADDR_EXT_ZERO 16'h0002
`define RIVM_ADDR_PIN_ZERO 16'h0004
`define RIVM_ADDR_PIN_TWO 16'h002e
`define RIVM_ADDR_SPI_DONE 16'h0018
`define RIVM_ADDR_PIN_ONE 16'h0006
`define RIVM_ADDR_TMR_TWO_CMP 16'h0008
`define RIVM_ADDR_TMR_ONE_CAPT 16'h000c
`define RIVM_ADDR_TMR_ONE_OVF 16'h0012
`define RIVM_ADDR_TMR_ZERO_OVF 16'h0016
`define RIVM_ADDR_USART_RX 16'h001a
`define RIVM_ADDR_SERIAL_START 16'h0020
`define RIVM_ADDR_EEPROM 16'h0028
`define RIVM_ADDR_SELF_PROG 16'h002a
`define RIVM_ADDR_PIN_THREE 16'h0030
`define RIVM_VEC_PIN_ZERO 5'h03
`define RIVM_VEC_PIN_ONE 5'h04
`define RIVM_VEC_TMR_TWO_CMP 5'h05
`define RIVM_VEC_TMR_ONE_CAPT 5'h07
`define RIVM_VEC_TMR_ONE_OVF 5'h0a
`define RIVM_VEC_TMR_ZERO_OVF 5'h0c
`define RIVM_VEC_SPI_DONE 5'h0d
`define RIVM_VEC_USART_RX 5'h0e
`define RIVM_VEC_SERIAL_START 5'h11
`define RIVM_VEC_EEPROM 5'h15
`define RIVM_VEC_SELF_PROG 5'h16
`define RIVM_VEC_PIN_TWO 5'h18
`define RIVM_VEC_PIN_THREE 5'h19

// ==========================================================================
// Fuse encoding
// ==========================================================================
`define RIVM_FUSE_PROGRAMMED 1'b0

`endif

// ==== src/rivm_pkg.sv ====
`include "rivm_defs.svh"

package rivm_pkg;

  // Reset sources that all lead to the reset vector.
  typedef struct packed {
    logic ext_pin;
    logic power_on;
    logic brown_out;
    logic watchdog;
    logic debug_port;
  } rivm_reset_cause_s;

  // Dispatch state, Gray coded.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01
  } rivm_state_e;

  typedef logic [`RIVM_ADDR_W-1:0] rivm_addr_t;
  typedef logic [`RIVM_NUM_W-1:0] rivm_num_t;

endpackage : rivm_pkg

// ==== src/rivm_addr_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rivm_defs.svh"

module rivm_addr_calc (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic is_reset,
  input wire rivm_pkg::rivm_num_t vec_num,
  input wire logic boot_fuse,
  input wire logic table_sel,
  input wire rivm_pkg::rivm_addr_t boot_entry,
  output rivm_pkg::rivm_addr_t addr_ff
);
  import rivm_pkg::*;

  // ========================================================================
  // Address arithmetic
  // ========================================================================
  // Reset base follows the fuse, interrupt base follows the select bit.
  wire logic fuse_prog = (boot_fuse == `RIVM_FUSE_PROGRAMMED);
  wire rivm_addr_t reset_base = fuse_prog ? boot_entry : `RIVM_RESET_ADDR;
  wire rivm_addr_t irq_base = table_sel ? boot_entry : `RIVM_APP_BASE;
  wire rivm_addr_t base = is_reset ? reset_base : irq_base;
  wire rivm_num_t slot = vec_num - `RIVM_VEC_RESET;
  // Two program words per slot, counted from vector one.
  wire rivm_addr_t offset = {{(`RIVM_ADDR_W-`RIVM_NUM_W-1){1'b0}}, slot, 1'b0};
  wire rivm_addr_t nxt_addr = base + offset;

  // The address register loads only when a new vector is captured.
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_ff <= `RIVM_RESET_ADDR;
    end else if (load) begin
      addr_ff <= nxt_addr;
    end
  end

endmodule : rivm_addr_calc

`default_nettype wire

// ==== tb/rivm_fetch_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Core fetch side: acknowledges a vector after a set delay.
// ==========================================================
module rivm_fetch_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic vec_valid,
  input wire logic [1:0] delay,
  output logic fetch_ack
);
  logic [1:0] wait_cnt;

  // A one-cycle pulse, so a stalled core never acks a later vector.
  always @(negedge clk) begin
    if (srst || !vec_valid || fetch_ack) begin
      fetch_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (wait_cnt == delay) begin
      fetch_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule : rivm_fetch_model

`default_nettype wire

// ==== tb/rivm_vector_map_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench for the vector map.
// ==========================================================
module rivm_vector_map_tb_top;
  import rivm_pkg::*;
  logic clk, srst, fuse, sel, ack, valid, is_rst;
  rivm_reset_cause_s cause;
  logic [23:0] irq;
  logic [1:0] delay;
  rivm_addr_t boot, addr;
  rivm_num_t num;
  int n_mismatch, checks;

  rivm_vector_map dut_u (.CLK(clk), .SRST(srst), .RESET_CAUSE(cause), .IRQ_REQ(irq),
    .BOOT_RESET_SELECT_FUSE(fuse), .VECTOR_TABLE_SELECT(sel), .BOOT_ENTRY_ADDR(boot),
    .FETCH_ACK(ack), .VEC_VALID(valid), .VEC_ADDR(addr), .VEC_NUM(num), .VEC_IS_RESET(is_rst));

  rivm_fetch_model core_u (.clk(clk), .srst(srst), .vec_valid(valid), .delay(delay),
    .fetch_ack(ack));

  // The clock toggles every 25 ns, giving a period of 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // Base is chosen by the fuse for reset and by the select for requests.
  function automatic logic [15:0] exp_addr(input int vn, input logic rst);
    logic [15:0] base;
    base = rst ? ((fuse == 1'b0) ? boot : 16'h0000) : (sel ? boot : 16'h0000);
    return base + 16'(2 * (vn - 1));
  endfunction : exp_addr

  // Waits for a vector, drops the requests and compares all outputs.
  task automatic take(input int vn);
    int i;
    for (i = 0; i < 20 && valid !== 1'b1; i++) @(negedge clk);
    irq = 24'h0;
    cause = '0;
    check({15'h0, valid}, 16'h0001);
    check({11'h0, num}, 16'(vn));
    check(addr, exp_addr(vn, vn == 1));
    check({15'h0, is_rst}, {15'h0, vn == 1});
    for (i = 0; i < 20 && valid !== 1'b0; i++) @(negedge clk);
    check({15'h0, valid}, 16'h0000);
    delay = 2'($urandom);
  endtask : take

  // Random inputs for the next request.
  task automatic setup;
    @(negedge clk);
    fuse = 1'($urandom);
    sel = 1'($urandom);
    boot = 16'($urandom) & 16'hfffe;
  endtask : setup

  // Main sequence: reset vector, every source, causes, priority.
  initial begin
    int b, k;
    logic [23:0] m;
    void'($urandom(32'h45935bab));
    srst = 1'b1;
    cause = '0;
    irq = 24'h0;
    delay = 2'h0;
    fuse = 1'b0;
    sel = 1'b0;
    boot = 16'h1c00;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    take(1);
    for (k = 0; k < 2; k++) begin
      for (b = 0; b < 24; b++) begin
        if (b == 21) continue;
        setup();
        irq[b] = 1'b1;
        take(b + 2);
      end
    end
    setup();
    irq[21] = 1'b1;
    repeat (6) @(negedge clk);
    check({15'h0, valid}, 16'h0000);
    irq[22] = 1'b1;
    take(24);
    for (b = 0; b < 5; b++) begin
      setup();
      cause = rivm_reset_cause_s'(5'h01 << b);
      irq = 24'($urandom) & 24'hdfffff;
      take(1);
      // A cause seen at the capture edge leaves a second reset pending.
      take(1);
    end
    // A reset in mid-run drops a presented vector and brings the reset vector back.
    setup();
    irq[0] = 1'b1;
    for (k = 0; k < 20 && valid !== 1'b1; k++) @(negedge clk);
    srst = 1'b1;
    irq = 24'h0;
    @(negedge clk);
    check({15'h0, valid}, 16'h0000);
    check(addr, 16'h0000);
    check({11'h0, num}, 16'h0000);
    srst = 1'b0;
    take(1);
    for (k = 0; k < 30; k++) begin
      setup();
      m = 24'($urandom) & 24'hdfffff;
      if (m == 24'h0) continue;
      for (b = 0; !m[b]; b++) begin
      end
      irq = m;
      take(b + 2);
    end
    end_of_test();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #(50 * 5000);
    n_mismatch++;
    end_of_test();
  end
endmodule : rivm_vector_map_tb_top

`default_nettype wire
